// ==== hdl/ccpt_pkg.sv ====
// Constants for the capture/compare/PWM timer: register indices, fields, resets.
// Assumes an APB master; byte address of a register is four times its index.

package ccpt_pkg;

  // ************************************************************
  // Register indices (byte address = index * 4)
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_PIN_SEL = 12'h0F7;
  localparam logic [11:0] IDX_MODE = 12'h120;
  localparam logic [11:0] IDX_CTL1 = 12'h121;
  localparam logic [11:0] IDX_IEN = 12'h122;
  localparam logic [11:0] IDX_STAT = 12'h123;
  localparam logic [11:0] IDX_IOC0 = 12'h124;
  localparam logic [11:0] IDX_IOC1 = 12'h125;
  localparam logic [11:0] IDX_CNT = 12'h126;
  localparam logic [11:0] IDX_GRA = 12'h128;
  localparam logic [11:0] IDX_GRB = 12'h12A;
  localparam logic [11:0] IDX_GRC = 12'h12C;
  localparam logic [11:0] IDX_GRD = 12'h12E;
  localparam logic [11:0] IDX_CTL2 = 12'h130;
  localparam logic [11:0] IDX_FILT = 12'h131;
  localparam logic [11:0] IDX_OMASK = 12'h132;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MODE_PWM_B = 0;
  localparam int MODE_TRIGGERED_WAIT_PWM = 3;
  localparam int MODE_BUF_C = 4;
  localparam int MODE_BUF_D = 5;
  localparam int MODE_RUN = 7;
  localparam int CTL1_INIT_A = 0;
  localparam int CTL1_SRC_LSB = 4;
  localparam int CTL1_COUNTER_CLEAR_SELECT = 7;
  localparam int CTL2_ONE_SHOT = 2;
  localparam int STAT_WRAP = 7;
  localparam int FILT_TRIG = 4;

  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [7:0] RST_OMASK = 8'h0F;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] SRC_F1 = 3'h0;
  localparam logic [2:0] SRC_F2 = 3'h1;
  localparam logic [2:0] SRC_F4 = 3'h2;
  localparam logic [2:0] SRC_F8 = 3'h3;
  localparam logic [2:0] SRC_F32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [2:0] SRC_OSC = 3'h6;
  localparam logic [1:0] OC_LOW = 2'h1;
  localparam logic [1:0] OC_HIGH = 2'h2;
  localparam logic [1:0] OC_TOGGLE = 2'h3;
  localparam int FILT_LEN = 3;

  typedef enum logic {CCPT_PW2_IDLE, CCPT_PW2_RUN} ccpt_pw2_t;

endpackage : ccpt_pkg

// ==== hdl/ccpt_timer.sv ====
// 16-bit capture/compare/PWM timer with four I/O pins, an APB register slave.
// Assumes pins, the external count clock, trigger and oscillator tick are
// synchronous to CLK_SYS; pin tristating is done outside from IO_PIN_OE.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns

module ccpt_timer (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ccpt_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Timer pins.
  input wire logic [3:0] IO_PIN_IN,
  output logic [3:0] IO_PIN_OUT,
  output logic [3:0] IO_PIN_OE,
  input wire logic EXT_COUNT_CLOCK_PIN,
  input wire logic TRIGGERED_WAIT_PWM_TRIGGER_PIN,
  input wire logic FAST_OSC_TICK,
  // Interrupt request.
  output logic IRQ
);
  import ccpt_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] pin_sel_ff, mode_ff, ctl1_ff, ien_ff, ioc0_ff, ioc1_ff;
  logic [7:0] ctl2_ff, filt_ff, omask_ff;
  logic [4:0] stat_ff, seen_ff, f_set;
  logic [15:0] cnt_ff;
  logic [15:0] gr_ff [4];
  logic pready_ff, slverr_ff;
  logic [31:0] prdata_ff, rd_mux;
  logic acc, wr, rd, mapped;
  logic [11:0] idx;
  logic [4:0] presc_ff;
  logic ext_prev_ff, tick, run, triggered_wait_pwm, pwm_any, timer, clr_en, cnt_go;
  logic wrap_ev, trig_ev, trig_en;
  logic [3:0] cap, pwm_pin, match_ev, cap_ev, out_ff, oe_ff;
  logic [2:0] iof [4];
  logic [4:0] lvl, prev_ff, flt_ff, rise, fall;
  logic [2:0] sh_ff [5];
  ccpt_pw2_t pw2_ff;

  // ************************************************************
  // APB slave
  // ************************************************************
  // One wait state so that read data can come straight from a flop.
  assign acc = PSEL & PENABLE;
  assign idx = PADDR[ADDR_W-1:2];
  assign wr = acc & pready_ff & PWRITE;
  assign rd = acc & pready_ff & ~PWRITE;
  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = slverr_ff;

  // Address decode and read multiplexer.
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IDX_PIN_SEL: rd_mux[7:0] = pin_sel_ff;
      IDX_MODE: rd_mux[7:0] = mode_ff;
      IDX_CTL1: rd_mux[7:0] = ctl1_ff;
      IDX_IEN: rd_mux[7:0] = ien_ff;
      IDX_STAT: rd_mux[7:0] = {stat_ff[4], 3'h0, stat_ff[3:0]};
      IDX_IOC0: rd_mux[7:0] = ioc0_ff;
      IDX_IOC1: rd_mux[7:0] = ioc1_ff;
      IDX_CNT: rd_mux[15:0] = cnt_ff;
      IDX_GRA: rd_mux[15:0] = gr_ff[0];
      IDX_GRB: rd_mux[15:0] = gr_ff[1];
      IDX_GRC: rd_mux[15:0] = gr_ff[2];
      IDX_GRD: rd_mux[15:0] = gr_ff[3];
      IDX_CTL2: rd_mux[7:0] = ctl2_ff;
      IDX_FILT: rd_mux[7:0] = filt_ff;
      IDX_OMASK: rd_mux[7:0] = omask_ff;
      default: mapped = 1'b0;
    endcase
  end

  // Ready, error and read data are captured in the first access cycle.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc & ~pready_ff;
      slverr_ff <= acc & ~pready_ff & ~mapped;
      if (acc && !pready_ff) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // Plain control registers; unmapped writes are dropped.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pin_sel_ff <= RST_REG8;
      mode_ff <= RST_REG8;
      ctl1_ff <= RST_REG8;
      ien_ff <= RST_REG8;
      ioc0_ff <= RST_REG8;
      ioc1_ff <= RST_REG8;
      ctl2_ff <= RST_REG8;
      filt_ff <= RST_REG8;
      omask_ff <= RST_OMASK;
    end else if (wr) begin
      if (idx == IDX_PIN_SEL) pin_sel_ff <= PWDATA[7:0];
      if (idx == IDX_MODE) mode_ff <= PWDATA[7:0];
      // changed by software only while stopped
      if (idx == IDX_CTL1) ctl1_ff <= PWDATA[7:0];
      if (idx == IDX_IEN) ien_ff <= PWDATA[7:0];
      if (idx == IDX_IOC0) ioc0_ff <= PWDATA[7:0];
      if (idx == IDX_IOC1) ioc1_ff <= PWDATA[7:0];
      if (idx == IDX_CTL2) ctl2_ff <= PWDATA[7:0];
      if (idx == IDX_FILT) filt_ff <= PWDATA[7:0];
      if (idx == IDX_OMASK) omask_ff <= PWDATA[7:0];
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  assign run = mode_ff[MODE_RUN];
  assign triggered_wait_pwm = mode_ff[MODE_TRIGGERED_WAIT_PWM];
  assign pwm_any = ~triggered_wait_pwm & (|mode_ff[MODE_PWM_B+2:MODE_PWM_B]);
  assign timer = ~triggered_wait_pwm & ~pwm_any;
  // I/O control fields only matter in timer mode
  assign iof[0] = ioc0_ff[2:0];
  assign iof[1] = ioc0_ff[6:4];
  assign iof[2] = ioc1_ff[2:0];
  assign iof[3] = ioc1_ff[6:4];

  // ************************************************************
  // Count source
  // ************************************************************
  // Free prescaler for the divided system-clock sources.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      presc_ff <= 5'h00;
      ext_prev_ff <= 1'b0;
    end else begin
      presc_ff <= presc_ff + 5'h01;
      ext_prev_ff <= EXT_COUNT_CLOCK_PIN;
    end
  end

  // the oscillator source counts on its tick, the divided sources on CLK_SYS
  // external clock pin counts on its rising edge
  always_comb begin
    unique case (ctl1_ff[CTL1_SRC_LSB+2:CTL1_SRC_LSB])
      SRC_F1: tick = 1'b1;
      SRC_F2: tick = &presc_ff[0:0];
      SRC_F4: tick = &presc_ff[1:0];
      SRC_F8: tick = &presc_ff[2:0];
      SRC_F32: tick = &presc_ff;
      SRC_EXT: tick = EXT_COUNT_CLOCK_PIN & ~ext_prev_ff;
      SRC_OSC: tick = FAST_OSC_TICK;
      default: tick = 1'b0;
    endcase
  end

  // ************************************************************
  // Input filters and edge detection (pins A-D, then trigger)
  // ************************************************************
  // A filtered level changes only after three equal samples, which costs
  // four cycles of latency but rejects glitches shorter than three cycles.
  for (genvar k = 0; k < 5; k++) begin : g_in
    logic raw, use_f;
    // The modulo keeps the unused pin index in range for the trigger slot.
    assign raw = (k == 4) ? TRIGGERED_WAIT_PWM_TRIGGER_PIN : IO_PIN_IN[k % 4];
    // filter only for capture inputs and the triggered-mode trigger
    assign use_f = filt_ff[k] & ((k == 4) ? triggered_wait_pwm : cap[k % 4]);
    assign lvl[k] = use_f ? flt_ff[k] : raw;
    assign rise[k] = lvl[k] & ~prev_ff[k];
    assign fall[k] = ~lvl[k] & prev_ff[k];
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
        sh_ff[k] <= 3'h0;
        flt_ff[k] <= 1'b0;
        prev_ff[k] <= 1'b0;
      end else begin
        sh_ff[k] <= {sh_ff[k][FILT_LEN-2:0], raw};
        if (&sh_ff[k] || ~|sh_ff[k]) flt_ff[k] <= sh_ff[k][0];
        prev_ff[k] <= lvl[k];
      end
    end
  end

  // ************************************************************
  // Per-pin function, capture and match events
  // ************************************************************
  for (genvar j = 0; j < 4; j++) begin : g_pin
    logic hit;
    assign cap[j] = timer & iof[j][2];
    assign pwm_pin[j] = (j == 0) ? 1'b0 : (triggered_wait_pwm ? (j == 1) : mode_ff[MODE_PWM_B + (j + 3) % 4]);
    // edge field 00 rising, 01 falling, 1x both
    assign hit = ((~iof[j][0] | iof[j][1]) & rise[j]) | ((iof[j][0] | iof[j][1]) & fall[j]);
    assign cap_ev[j] = run & cap[j] & hit;
    // equality with the general register, even when buffering
    assign match_ev[j] = cnt_go & (cnt_ff == gr_ff[j]);
    assign f_set[j] = cap[j] ? cap_ev[j] : match_ev[j];
  end

  assign wrap_ev = cnt_go & (cnt_ff == CNT_MAX);
  assign f_set[4] = wrap_ev;

  // ************************************************************
  // Triggered-wait PWM sequencer
  // ************************************************************
  // control two only steers this sequencer
  assign trig_en = |ctl2_ff[1:0];
  assign trig_ev = (ctl2_ff[0] & rise[4]) | (ctl2_ff[1] & fall[4]);

  // wait for trigger, count a period, stop after one if one-shot
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pw2_ff <= CCPT_PW2_IDLE;
    end else begin
      unique case (pw2_ff)
        CCPT_PW2_IDLE: begin
          if (run && triggered_wait_pwm && (trig_ev || !trig_en)) pw2_ff <= CCPT_PW2_RUN;
        end
        CCPT_PW2_RUN: begin
          if (!run || !triggered_wait_pwm) begin
            pw2_ff <= CCPT_PW2_IDLE;
          end else if (match_ev[0] && ctl2_ff[CTL2_ONE_SHOT]) begin
            pw2_ff <= CCPT_PW2_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  assign cnt_go = run & tick & (~triggered_wait_pwm | (pw2_ff == CCPT_PW2_RUN));
  assign clr_en = triggered_wait_pwm | pwm_any | (ctl1_ff[CTL1_COUNTER_CLEAR_SELECT] & ~|cap);

  // sixteen-bit up counter, cleared at the register A match in the PWM modes, or with clear select set and no capture pin
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cnt_ff <= RST_REG16;
    end else if (wr && idx == IDX_CNT) begin
      cnt_ff <= PWDATA[15:0];
    end else if (triggered_wait_pwm && pw2_ff == CCPT_PW2_IDLE) begin
      cnt_ff <= RST_REG16;
    end else if (cnt_go) begin
      cnt_ff <= (clr_en && match_ev[0]) ? RST_REG16 : cnt_ff + 16'h0001;
    end
  end

  // ************************************************************
  // General registers with capture and buffer transfers
  // ************************************************************
  // Hardware transfers follow the software write so that they win.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      for (int g = 0; g < 4; g++) gr_ff[g] <= RST_REG16;
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (wr && idx == IDX_GRA + 12'(2 * g)) gr_ff[g] <= PWDATA[15:0];
        // capture the counter on the selected edge
        if (cap_ev[g]) gr_ff[g] <= cnt_ff;
      end
      // Buffer on capture: the old A or B value moves to C or D.
      if (mode_ff[MODE_BUF_C] && cap_ev[0]) gr_ff[2] <= gr_ff[0];
      if (mode_ff[MODE_BUF_D] && cap_ev[1]) gr_ff[3] <= gr_ff[1];
      // Buffer on compare: C or D reloads A or B at the A or B match.
      if (mode_ff[MODE_BUF_C] && !cap[0] && match_ev[0] && !triggered_wait_pwm) gr_ff[0] <= gr_ff[2];
      if (mode_ff[MODE_BUF_D] && !cap[1] && match_ev[triggered_wait_pwm ? 0 : 1]) gr_ff[1] <= gr_ff[3];
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  for (genvar j = 0; j < 4; j++) begin : g_out
    logic init;
    assign init = ctl1_ff[CTL1_INIT_A+j];
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
        out_ff[j] <= 1'b0;
        oe_ff[j] <= 1'b0;
      end else begin
        // mask gates outputs only, never a capture pin
        oe_ff[j] <= ~omask_ff[j] & (pwm_pin[j] | (timer & ~cap[j] & (|iof[j][1:0])));
        if (!run || (triggered_wait_pwm && pw2_ff == CCPT_PW2_IDLE)) begin
          // initial level has no effect on a capture pin (not driven)
          out_ff[j] <= init;
        end else if (pwm_pin[j]) begin
          // period restarts at A match, width ends at own match
          if (match_ev[j]) begin
            out_ff[j] <= ~init;
          end else if (match_ev[0]) begin
            out_ff[j] <= init;
          end
        end else if (timer && !cap[j] && match_ev[j]) begin
          unique case (iof[j][1:0])
            OC_LOW: out_ff[j] <= 1'b0;
            OC_HIGH: out_ff[j] <= 1'b1;
            OC_TOGGLE: out_ff[j] <= ~out_ff[j];
            default: out_ff[j] <= out_ff[j];
          endcase
        end
      end
    end
  end

  assign IO_PIN_OUT = out_ff;
  assign IO_PIN_OE = oe_ff;

  // ************************************************************
  // Status flags and interrupt request
  // ************************************************************
  // A flag may be cleared only after software has read it as one; a new
  // event in the clearing cycle wins, so no event is lost.
  for (genvar f = 0; f < 5; f++) begin : g_flag
    localparam int BP = (f == 4) ? STAT_WRAP : f;
    logic clr;
    // clear by writing 0 after reading 1
    assign clr = wr & (idx == IDX_STAT) & ~PWDATA[BP] & seen_ff[f];
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
        stat_ff[f] <= 1'b0;
        seen_ff[f] <= 1'b0;
      end else begin
        // an event in the write cycle survives the write
        stat_ff[f] <= f_set[f] | (stat_ff[f] & ~clr);
        // Remember what the read returned, not the live flag: a flag set in
        // the wait state was never seen by software and must survive.
        if (rd && idx == IDX_STAT) begin
          seen_ff[f] <= prdata_ff[BP];
        end else if (wr && idx == IDX_STAT) begin
          seen_ff[f] <= 1'b0;
        end
      end
    end
  end

  // request while an enabled flag is set
  assign IRQ = |(stat_ff & {ien_ff[STAT_WRAP], ien_ff[3:0]});

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  sequence s_read_one;
    rd && idx == IDX_STAT && prdata_ff[0];
  endsequence
  sequence s_write_zero;
    wr && idx == IDX_STAT && !PWDATA[0] && !f_set[0];
  endsequence

  property p_flag_clear;
    s_read_one ##[3:4] s_write_zero |=> !stat_ff[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_keep;
    stat_ff[0] && !seen_ff[0] |=> stat_ff[0];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("unread flag lost");

  property p_write_one;
    wr && idx == IDX_STAT && PWDATA[1] && stat_ff[1] |=> stat_ff[1];
  endproperty
  a_write_one: assert property (p_write_one) else $error("flag cleared by one");

  property p_capture;
    cap_ev[0] |=> gr_ff[0] == $past(cnt_ff);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_compare_high;
    run && timer && !cap[0] && iof[0][1:0] == OC_HIGH && match_ev[0] |=> IO_PIN_OUT[0];
  endproperty
  a_compare_high: assert property (p_compare_high) else $error("compare no output");

  property p_free_run;
    cap[0] && cnt_go && cnt_ff != CNT_MAX && !(wr && idx == IDX_CNT)
      |=> cnt_ff == $past(cnt_ff) + 16'h0001;
  endproperty
  a_free_run: assert property (p_free_run) else $error("capture counter cleared");

  property p_match_flag;
    match_ev[1] && !cap[1] |=> stat_ff[1];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missing");

  property p_wrap;
    wrap_ev |=> stat_ff[4] && (cnt_ff == RST_REG16 || $past(wr && idx == IDX_CNT));
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow flag missing");

  property p_triggered_wait_pwm_pin_a;
    triggered_wait_pwm |=> !IO_PIN_OE[0];
  endproperty
  a_triggered_wait_pwm_pin_a: assert property (p_triggered_wait_pwm_pin_a) else $error("pin A driven");

  property p_capture_no_drive;
    cap[2] |=> !IO_PIN_OE[2];
  endproperty
  a_capture_no_drive: assert property (p_capture_no_drive) else $error("capture pin driven");

  property p_irq;
    wrap_ev && ien_ff[STAT_WRAP] |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule : ccpt_timer

// ==== dv/ccpt_pin_model.sv ====
// Outside world of the timer pins: pin levels, external count clock, fast ticks.
// Assumes the bench sets wanted levels on lvl just after rising clock edges.
`timescale 1ns/1ns

module ccpt_pin_model (
  // Clock.
  input wire logic clk,
  // Wanted outside levels and the timer's own drive.
  input wire logic [3:0] lvl,
  input wire logic [3:0] oe,
  input wire logic [3:0] out,
  // Timer inputs.
  output logic [3:0] pin_in,
  output logic ext_clk,
  output logic osc_tick
);
  logic [1:0] ext_cnt_ff = 2'h0;
  logic [2:0] osc_cnt_ff = 3'h0;
  logic ext_ff = 1'b0;

  // The timer wins where it drives, so a compare pin reads back its own level.
  assign pin_in = (oe & out) | (~oe & lvl);
  assign ext_clk = ext_ff;
  // fast oscillator ticks
  // Two ticks in five cycles stands in for 40 MHz against 100 MHz.
  assign osc_tick = (osc_cnt_ff == 3'h0) || (osc_cnt_ff == 3'h3);

  // external count clock
  // Three cycles high and three low; the timer accepts as little as one cycle of each.
  always_ff @(posedge clk) begin
    ext_cnt_ff <= (ext_cnt_ff == 2'h2) ? 2'h0 : ext_cnt_ff + 2'h1;
    ext_ff <= (ext_cnt_ff == 2'h2) ? ~ext_ff : ext_ff;
    osc_cnt_ff <= (osc_cnt_ff == 3'h4) ? 3'h0 : osc_cnt_ff + 3'h1;
  end
endmodule : ccpt_pin_model

// ==== dv/capture_compare_pwm_timer_tb.sv ====
// Self-checking bench of the timer: registers, compare, capture, flags, sources.
// Assumes the APB slave answers with a wait state and the pin model outside.
`timescale 1ns/1ns

module capture_compare_pwm_timer_tb;
  import ccpt_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rdv, c1, c2;
  logic pready, pslverr, errv, irq, ext_clk, osc_tick;
  logic [3:0] lvl = 4'h0;
  logic trg = 1'b0;
  logic [3:0] pin_in, pin_out, pin_oe;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int g;
  logic [11:0] idx_tab [15] = '{IDX_PIN_SEL, IDX_MODE, IDX_CTL1, IDX_IEN, IDX_STAT,
    IDX_IOC0, IDX_IOC1, IDX_CNT, IDX_GRA, IDX_GRB, IDX_GRC, IDX_GRD, IDX_CTL2,
    IDX_FILT, IDX_OMASK};

  always #5 clk_sys = ~clk_sys;

  ccpt_timer ccpt_timer_i (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IO_PIN_IN(pin_in),
    .IO_PIN_OUT(pin_out), .IO_PIN_OE(pin_oe), .EXT_COUNT_CLOCK_PIN(ext_clk),
    .TRIGGERED_WAIT_PWM_TRIGGER_PIN(trg), .FAST_OSC_TICK(osc_tick), .IRQ(irq));

  ccpt_pin_model ccpt_pin_model_i (.clk(clk_sys), .lvl(lvl), .oe(pin_oe),
    .out(pin_out), .pin_in(pin_in), .ext_clk(ext_clk), .osc_tick(osc_tick));

  // ************************************************************
  // Bus and checking tasks
  // ************************************************************
  // One APB transfer; the request is held until PREADY is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees PREADY.
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // A hang counts as a mismatch and ends the run with the normal verdict.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(4809));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      apb(1'b0, idx_tab[i], 32'h0);
      chk(rdv, (i == 14) ? 32'h0000000F : 32'h0);
    end
    apb(1'b1, 12'h0FF, 32'hFF);
    chk({31'h0, errv}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      g = $urandom;
      apb(1'b1, IDX_GRA + 12'(2 * i), g);
      apb(1'b0, IDX_GRA + 12'(2 * i), 32'h0);
      chk(rdv, {16'h0, g[15:0]});
    end
    $display("test registers done");
    // Compare-high on pin A at a random match value.
    g = 20 + ($urandom % 40);
    apb(1'b1, IDX_OMASK, 32'h0);
    apb(1'b1, IDX_IOC0, 32'h02);
    apb(1'b1, IDX_CNT, 32'h0);
    apb(1'b1, IDX_GRA, g);
    apb(1'b1, IDX_CTL1, 32'h0);
    apb(1'b1, IDX_MODE, 32'h80);
    chk({31'h0, pin_out[0]}, 32'h0);
    repeat (g + 5) @(posedge clk_sys);
    chk({30'h0, pin_oe[0], pin_out[0]}, 32'h3);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h1, 32'h1);
    apb(1'b1, IDX_MODE, 32'h0);
    $display("test compare done");
    // Capture on pins A and B, flag clearing and the interrupt request.
    apb(1'b1, IDX_IOC0, 32'h44);
    apb(1'b1, IDX_IOC1, 32'h04);
    apb(1'b0, IDX_STAT, 32'h0);
    apb(1'b1, IDX_STAT, 32'h0);
    apb(1'b1, IDX_IEN, 32'h01);
    apb(1'b1, IDX_CNT, 32'h0);
    apb(1'b1, IDX_MODE, 32'h80);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, IDX_CNT, 32'h0);
    c1 = rdv;
    lvl <= 4'h1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, IDX_CNT, 32'h0);
    c2 = rdv;
    apb(1'b0, IDX_GRA, 32'h0);
    chk(32'(rdv > c1 && rdv < c2), 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h3, 32'h1);
    apb(1'b1, IDX_STAT, 32'h01);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h3, 32'h1);
    apb(1'b1, IDX_STAT, 32'h0);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h3, 32'h0);
    lvl <= 4'h3;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, IDX_STAT, 32'h0);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h3, 32'h2);
    apb(1'b1, IDX_STAT, 32'h02);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h3, 32'h2);
    chk({31'h0, irq}, 32'h0);
    $display("test capture done");
    // Every count source code; code seven selects nothing and must not count.
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_MODE, 32'h0);
      apb(1'b1, IDX_CNT, 32'h0);
      apb(1'b1, IDX_CTL1, 32'(c) << 4);
      apb(1'b1, IDX_MODE, 32'h80);
      repeat (40) @(posedge clk_sys);
      apb(1'b1, IDX_MODE, 32'h0);
      apb(1'b0, IDX_CNT, 32'h0);
      chk(32'(rdv != 0), 32'(c != 7));
    end
    $display("test sources done");
    // Triggered mode: counter held until the trigger, one pulse on pin B, then stop.
    apb(1'b1, IDX_CTL1, 32'h0);
    apb(1'b1, IDX_GRA, 32'h28);
    apb(1'b1, IDX_GRB, 32'h0A);
    apb(1'b1, IDX_CTL2, 32'h05);
    apb(1'b0, IDX_STAT, 32'h0);
    apb(1'b1, IDX_STAT, 32'h0);
    apb(1'b1, IDX_MODE, 32'h88);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, IDX_CNT, 32'h0);
    chk(rdv, 32'h0);
    trg <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
    chk({31'h0, pin_oe[0]}, 32'h0);
    repeat (30) @(posedge clk_sys);
    chk({31'h0, pin_out[1]}, 32'h0);
    apb(1'b0, IDX_CNT, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h3, 32'h3);
    apb(1'b1, IDX_MODE, 32'h0);
    $display("test triggered mode done");
    // Wrap of the counter from just below its top.
    apb(1'b1, IDX_CNT, 32'hFFF0);
    apb(1'b1, IDX_CTL1, 32'h0);
    apb(1'b1, IDX_IEN, 32'h80);
    apb(1'b0, IDX_STAT, 32'h0);
    apb(1'b1, IDX_STAT, 32'h0);
    apb(1'b1, IDX_MODE, 32'h80);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, IDX_STAT, 32'h0);
    chk(rdv & 32'h80, 32'h80);
    chk({31'h0, irq}, 32'h1);
    $display("test overflow done");
    report_and_stop();
  end
endmodule : capture_compare_pwm_timer_tb
